// ===== logic/imusrp_pkg.sv
// Package of constants for the inertial sensor serial read port
package imusrp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SAMPLE_RATE_SPS = 1024;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_SPS;
  localparam int unsigned SAMPLE_CNT_W = 16;
  // ----------------------------------------
  // Command layout
  // ----------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BIT_CNT_W = 4;
  localparam logic [7:0] ADDR_FIRST = 8'h04;
  localparam logic [7:0] ADDR_LAST = 8'h12;
  localparam logic [7:0] BURST_CMD = 8'h3E;
  localparam int unsigned NUM_OUT = 8;
  localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage

// ===== logic/imusrp_fifo.sv
// Sample word FIFO between the sample source and the output registers
`timescale 1ns/1ps
`default_nettype none
module imusrp_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign do_wr = in_valid && !full;
  assign do_rd = out_ready && !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_comb
  begin
    next_wr_ptr = wr_ptr + (AW+1)'(do_wr);
    next_rd_ptr = rd_ptr + (AW+1)'(do_rd);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== logic/imusrp_top.sv
// Serial slave read port and sample timing of a six-axis inertial module
`timescale 1ns/1ps
`default_nettype none
module imusrp_top #(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned SAMPLE_CYCLES = imusrp_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Serial link from the master
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // Sensor sample stream
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [15:0] smp_data,
  // Multipurpose pin and data ready
  input wire logic sync_mode,
  input wire logic sync_clock_input_in,
  output logic sync_clock_input_out,
  output logic sync_clock_input_oe,
  input wire logic gpio_out_val,
  input wire logic gpio_out_en,
  output logic gpio_in_val,
  output logic data_ready_pin
);
  // ----------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [3:0] sy1;
  logic [3:0] sy2;
  logic sclk_prev;
  logic sync_prev;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1 <= 4'hB;
      sy2 <= 4'hB;
      sclk_prev <= 1'b1;
      // Matches the synchroniser's reset level so reset makes no false edge
      sync_prev <= 1'b1;
    end
    else
    begin
      sy1 <= {sync_clock_input_in, din, cs_n, sclk};
      sy2 <= sy1;
      sclk_prev <= sy2[0];
      sync_prev <= sy2[3];
    end
  end
  logic s_sclk;
  logic s_cs_n;
  logic s_din;
  logic s_sync;
  assign s_sclk = sy2[0];
  assign s_cs_n = sy2[1];
  assign s_din = sy2[2];
  assign s_sync = sy2[3];
  logic sclk_rise;
  logic sclk_fall;
  logic sync_rise;
  assign sclk_rise = s_sclk && !sclk_prev && !s_cs_n;
  assign sclk_fall = !s_sclk && sclk_prev && !s_cs_n;
  assign sync_rise = s_sync && !sync_prev;

  // ----------------------------------------
  // Sample timing
  // ----------------------------------------
  logic [imusrp_pkg::SAMPLE_CNT_W-1:0] smp_cnt;
  logic [imusrp_pkg::SAMPLE_CNT_W-1:0] next_smp_cnt;
  logic tick;
  always_comb
  begin
    tick = 1'b0;
    next_smp_cnt = smp_cnt + 16'h0001;
    if (sync_mode)
    begin
      tick = sync_rise;
      next_smp_cnt = 16'h0000;
    end
    else if (smp_cnt == 16'(SAMPLE_CYCLES - 1))
    begin
      tick = 1'b1;
      next_smp_cnt = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smp_cnt <= 16'h0000;
    end
    else
    begin
      smp_cnt <= next_smp_cnt;
    end
  end

  // ----------------------------------------
  // Sample FIFO and output register bank
  // ----------------------------------------
  logic f_valid;
  logic f_ready;
  logic [15:0] f_data;
  imusrp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data(smp_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  logic [15:0] stage [imusrp_pkg::NUM_OUT];
  logic [15:0] outreg [imusrp_pkg::NUM_OUT];
  logic [2:0] fill_idx;
  logic [2:0] next_fill_idx;
  logic set_full;
  logic next_set_full;
  logic commit;
  logic busy;
  logic data_ready;
  logic next_data_ready;

  // Commit skips any tick at which the master holds select so a read never sees a torn word
  assign commit = tick && set_full && s_cs_n;
  assign f_ready = !set_full;
  always_comb
  begin
    next_fill_idx = fill_idx;
    next_set_full = set_full && !commit;
    if (f_valid && !set_full)
    begin
      next_fill_idx = fill_idx + 3'h1;
      if (fill_idx == 3'(imusrp_pkg::NUM_OUT - 1))
      begin
        next_set_full = 1'b1;
      end
    end
    next_data_ready = commit;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fill_idx <= 3'h0;
      set_full <= 1'b0;
      data_ready <= 1'b0;
    end
    else
    begin
      fill_idx <= next_fill_idx;
      set_full <= next_set_full;
      data_ready <= next_data_ready;
    end
  end

  genvar g;
  generate
    for (g = 0; g < imusrp_pkg::NUM_OUT; g++)
    begin : g_regs
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage[g] <= imusrp_pkg::RESET_WORD;
          outreg[g] <= imusrp_pkg::RESET_WORD;
        end
        else
        begin
          if (f_valid && !set_full && fill_idx == 3'(g))
          begin
            stage[g] <= f_data;
          end
          if (commit)
          begin
            outreg[g] <= stage[g];
          end
        end
      end
    end
  endgenerate

  // Register address to output index; addresses outside 0x04..0x12 read zero
  function automatic logic [3:0] addr_idx(input logic [7:0] a);
    if (a >= imusrp_pkg::ADDR_FIRST && a <= imusrp_pkg::ADDR_LAST && !a[0])
    begin
      addr_idx = {1'b0, 3'((a - imusrp_pkg::ADDR_FIRST) >> 1)};
    end
    else
    begin
      addr_idx = 4'h8;
    end
  endfunction

  // ----------------------------------------
  // Serial slave
  // ----------------------------------------
  logic [15:0] rx_sh;
  logic [15:0] next_rx_sh;
  logic [15:0] tx_sh;
  logic [15:0] next_tx_sh;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [3:0] pend;
  logic [3:0] next_pend;
  logic burst;
  logic next_burst;
  logic [2:0] b_idx;
  logic [2:0] next_b_idx;
  logic dout_q;
  logic next_dout;
  logic [15:0] rx_word;
  logic [3:0] rd_sel;
  assign rx_word = {rx_sh[14:0], s_din};
  assign rd_sel = addr_idx(rx_word[15:8]);
  assign busy = !s_cs_n;

  always_comb
  begin
    next_rx_sh = rx_sh;
    next_tx_sh = tx_sh;
    next_bit_cnt = bit_cnt;
    next_pend = pend;
    next_burst = burst;
    next_b_idx = b_idx;
    next_dout = dout_q;
    if (s_cs_n)
    begin
      // Select high ends any burst and restarts word framing
      next_bit_cnt = 4'h0;
      next_burst = 1'b0;
      next_tx_sh = pend[3] ? 16'h0000 : outreg[pend[2:0]];
      next_dout = next_tx_sh[15];
    end
    else
    begin
      // Every fall, the first too: in a burst no select edge preloads the next MSB
      if (sclk_fall)
      begin
        next_dout = tx_sh[15];
      end
      if (sclk_rise)
      begin
        next_rx_sh = rx_word;
        next_tx_sh = {tx_sh[14:0], 1'b0};
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == 4'hF)
        begin
          if (burst)
          begin
            // Next register follows with no new command
            next_b_idx = b_idx + 3'h1;
            next_tx_sh = outreg[b_idx];
            if (b_idx == 3'(imusrp_pkg::NUM_OUT - 1))
            begin
              next_burst = 1'b0;
            end
          end
          else if (rx_word[15:8] == imusrp_pkg::BURST_CMD)
          begin
            next_burst = 1'b1;
            next_b_idx = 3'h1;
            next_tx_sh = outreg[0];
          end
          else
          begin
            next_pend = rx_word[15] ? 4'h8 : rd_sel;
            next_tx_sh = next_pend[3] ? 16'h0000 : outreg[next_pend[2:0]];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sh <= 16'h0000;
      tx_sh <= 16'h0000;
      bit_cnt <= 4'h0;
      pend <= 4'h8;
      burst <= 1'b0;
      b_idx <= 3'h0;
      dout_q <= 1'b0;
    end
    else
    begin
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
      bit_cnt <= next_bit_cnt;
      pend <= next_pend;
      burst <= next_burst;
      b_idx <= next_b_idx;
      dout_q <= next_dout;
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  logic gp_out;
  logic gp_oe;
  logic gp_in;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gp_out <= 1'b0;
      gp_oe <= 1'b0;
      gp_in <= 1'b0;
    end
    else
    begin
      gp_out <= gpio_out_val;
      gp_oe <= gpio_out_en && !sync_mode;
      gp_in <= s_sync;
    end
  end
  assign sync_clock_input_out = gp_out;
  assign sync_clock_input_oe = gp_oe;
  assign gpio_in_val = gp_in;
  assign dout = dout_q;
  assign data_ready_pin = data_ready;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_drdy_pulse;
    @(posedge ref_clk) disable iff (!rst_n) data_ready |=> !data_ready;
  endproperty
  a_drdy_pulse: assert property (p_drdy_pulse) else $error("data ready longer than one cycle");
  property p_drdy_cause;
    @(posedge ref_clk) disable iff (!rst_n) $rose(data_ready) |-> $past(tick) && $past(s_cs_n);
  endproperty
  a_drdy_cause: assert property (p_drdy_cause) else $error("data ready without sample end");
  property p_tick_period;
    @(posedge ref_clk) disable iff (!rst_n) (!sync_mode && smp_cnt == 16'h0000) |-> !tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("sample tick at wrong count");
  property p_stable;
    @(posedge ref_clk) disable iff (!rst_n) busy && $past(busy) |-> $stable(outreg[0]);
  endproperty
  a_stable: assert property (p_stable) else $error("output register changed during read");
  property p_dout_fall;
    @(posedge ref_clk) disable iff (!rst_n) (!s_cs_n && $changed(dout_q)) |-> $past(sclk_fall);
  endproperty
  a_dout_fall: assert property (p_dout_fall) else $error("dout moved off a falling edge");
  property p_shift_rise;
    @(posedge ref_clk) disable iff (!rst_n) (!s_cs_n && $changed(rx_sh)) |-> $past(sclk_rise);
  endproperty
  a_shift_rise: assert property (p_shift_rise) else $error("input shifted off a rising edge");
  property p_burst_start;
    @(posedge ref_clk) disable iff (!rst_n)
      (sclk_rise && bit_cnt == 4'hF && !burst && rx_word[15:8] == imusrp_pkg::BURST_CMD)
      |=> burst && tx_sh == outreg[0];
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst did not start");
  property p_pend;
    @(posedge ref_clk) disable iff (!rst_n)
      (sclk_rise && bit_cnt == 4'hF && !burst && rx_word[15:8] == 8'h06) |=> pend == 4'h1;
  endproperty
  a_pend: assert property (p_pend) else $error("read request not latched");
  property p_cs_end;
    @(posedge ref_clk) disable iff (!rst_n) s_cs_n |=> bit_cnt == 4'h0 && !burst;
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("framing not reset by select");
  property p_sync_oe;
    @(posedge ref_clk) disable iff (!rst_n) sync_mode && $past(sync_mode) |-> !gp_oe;
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("pin driven in sync mode");
  c_burst: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(burst));
  c_drdy: cover property (@(posedge ref_clk) disable iff (!rst_n) data_ready);
  c_read: cover property (@(posedge ref_clk) disable iff (!rst_n) pend == 4'h0);
endmodule
`default_nettype wire

// ===== bench/imusrp_master.sv
// Serial master model that drives the read port's link pins
`timescale 1ns/1ps
`default_nettype none
module imusrp_master #(
  parameter int HALF = 250
) (
  // Link pins
  output var logic sclk,
  output var logic cs_n,
  output var logic din,
  input wire logic dout
);
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // One word; hold keeps select low so a burst runs on
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, input bit hold);
    if (cs_n)
    begin
      cs_n = 1'b0;
      #HALF;
    end
    for (int i = 15; i >= 0; i--)
    begin
      sclk = 1'b0;
      din = tx[i];
      #HALF;
      sclk = 1'b1;
      rx[i] = dout;
      #HALF;
    end
    // Released line shows the inverse, never the last bit
    din = ~tx[0];
    if (hold)
      #(2 * HALF);
    else
    begin
      cs_n = 1'b1;
      #9000;
    end
  endtask
endmodule
`default_nettype wire

// ===== bench/imusrp_bench.sv
// Self-checking bench for the inertial read port
`timescale 1ns/1ps
`default_nettype none
module imusrp_bench;
  localparam int SC = 64;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic smp_valid = 1'b0;
  logic [15:0] smp_data = 16'h0000;
  logic sync_mode = 1'b0;
  logic pin_drv = 1'b0;
  logic gpio_val = 1'b0;
  logic gpio_en = 1'b0;
  logic sclk, cs_n, din, dout, smp_ready, pin_out, pin_oe, gpio_in, drdy, was, long_pulse;
  logic [15:0] rx;
  wire pin = pin_oe ? pin_out : pin_drv;
  int miscompares = 0;
  int n_checks = 0;
  int npush = 0;
  int npulse = 0;
  int cyc = 0;
  int last_cyc = -1;
  imusrp_top #(.SAMPLE_CYCLES(SC)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_data(smp_data), .sync_mode(sync_mode),
    .sync_clock_input_in(pin), .sync_clock_input_out(pin_out),
    .sync_clock_input_oe(pin_oe), .gpio_out_val(gpio_val), .gpio_out_en(gpio_en),
    .gpio_in_val(gpio_in), .data_ready_pin(drdy));
  imusrp_master i_master (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  initial
  begin
    was = 1'b0;
    long_pulse = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----
  // Checking
  // ----
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  // Ticks may be skipped, so in timer mode pulses land on whole sample periods
  always @(negedge ref_clk)
  begin
    cyc++;
    if (drdy && was)
      long_pulse = 1'b1;
    was = drdy;
    if (drdy === 1'b1)
    begin
      if (!sync_mode && last_cyc >= 0)
        chk1((cyc - last_cyc) % SC == 0, 1'b1);
      last_cyc = cyc;
      npulse++;
    end
  end
  function automatic logic [15:0] val(input int n);
    return 16'hC000 + 16'(n) * 16'h0111;
  endfunction
  task push(output bit ok);
    @(negedge ref_clk);
    smp_data = val(npush);
    smp_valid = 1'b1;
    ok = smp_ready;
    @(negedge ref_clk);
    smp_valid = 1'b0;
    if (ok)
      npush++;
  endtask
  task push8;
    bit ok;
    for (int i = 0; i < 8; i++)
      push(ok);
  endtask
  task wait_sets(input int want);
    for (int k = 0; k < 4000 && npulse < want; k++)
      @(negedge ref_clk);
    chk1(npulse >= want, 1'b1);
  endtask
  task xr(input logic [15:0] tx, input logic [15:0] exp);
    i_master.xfer(tx, rx, 1'b0);
    chk16(rx, exp);
  endtask
  // ----
  // Scenarios
  // ----
  task t_boot;
    push8;
    wait_sets(1);
    push8;
    wait_sets(2);
    $display("test boot done");
  endtask
  task t_single;
    int b;
    b = 8 * (npulse - 1);
    i_master.xfer(16'h0400, rx, 1'b0);
    xr(16'h06FF, val(b));
    xr(16'h08A5, val(b + 1));
    xr(16'h1200, val(b + 2));
    xr(16'h8400, val(b + 7));
    xr(16'h1400, 16'h0000);
    xr(16'h0000, 16'h0000);
    $display("test single done");
  endtask
  task t_burst;
    int b;
    bit ok;
    b = 8 * (npulse - 1);
    fork
      begin
        i_master.xfer(16'h3E00, rx, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
          i_master.xfer(16'h0000, rx, i < 7);
          chk16(rx, val(b + i));
        end
      end
      begin
        ok = 1'b1;
        for (int k = 0; k < 64 && ok; k++)
          push(ok);
        chk1(ok, 1'b0);
      end
    join
    wait_sets(npush / 8);
    chk1(smp_ready, 1'b1);
    i_master.xfer(16'h0400, rx, 1'b0);
    xr(16'h0000, val(8 * (npulse - 1)));
    $display("test burst done");
  endtask
  task t_pins;
    int n;
    @(negedge ref_clk);
    gpio_en = 1'b1;
    gpio_val = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk1(pin_oe, 1'b1);
    chk1(pin_out, 1'b1);
    gpio_en = 1'b0;
    pin_drv = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk1(gpio_in, 1'b1);
    sync_mode = 1'b1;
    push8;
    n = npulse;
    repeat (3 * SC) @(negedge ref_clk);
    chk1(pin_oe, 1'b0);
    chk1(npulse == n, 1'b1);
    pin_drv = 1'b0;
    repeat (10) @(negedge ref_clk);
    pin_drv = 1'b1;
    wait_sets(n + 1);
    $display("test pins done");
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #1ms;
    miscompares++;
    wrap_up;
  end
  initial
  begin
    repeat (20) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_boot;
    t_single;
    t_burst;
    t_pins;
    chk1(long_pulse, 1'b0);
    wrap_up;
  end
endmodule
`default_nettype wire
